//--- rtl/eeprom_host_params.svh
// Constants for the paged nonvolatile memory host controller
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH
`define ADDR_W            17
`define DATA_W            8
`define PAGE_BYTES        128
`define BYTE_ADDR_W       7
`define CLK_MHZ           40
`define STROBE_NS         100
`define SETUP_NS          50
`define LOAD_WINDOW_US    150
`define PROGRAM_MS        10
`define POWERUP_MS        5
`define STROBE_CYC        ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define SETUP_CYC         ((`SETUP_NS * `CLK_MHZ + 999) / 1000)
`define LOAD_WINDOW_CYC   ((`LOAD_WINDOW_US * `CLK_MHZ) * 3 / 4)
`define PROGRAM_CYC       (`PROGRAM_MS * 1000 * `CLK_MHZ)
`define POWERUP_CYC       (`POWERUP_MS * 1000 * `CLK_MHZ)
`define CMD_ADDR0         17'h05555
`define CMD_ADDR1         17'h02aaa
`define CMD_ADDR2         17'h05555
`define CMD_DATA0         8'haa
`define CMD_DATA1         8'h55
`define LOCK_ON_DATA      8'ha0
`define LOCK_OFF_DATA2    8'h80
`endif

//--- rtl/eeprom_host_pkg.sv
// Types for the paged nonvolatile memory host controller
`include "eeprom_host_params.svh"
package eeprom_host_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } mem_word_t;
  typedef enum logic [1:0] {
    op_read   = 2'b00,
    op_write  = 2'b01,
    op_lock   = 2'b10,
    op_unlock = 2'b11
  } op_t;
  typedef struct packed {
    op_t       op;
    logic      last;
    mem_word_t word;
  } request_t;
  typedef struct packed {
    logic                chip_select_n;
    logic                output_enable_n;
    logic                write_strobe_n;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  data_out;
    logic                data_oe;
  } pins_t;
endpackage

//--- rtl/cycle_timer.sv
// Loadable down counter used for power-up, setup, strobe, window and poll read timing
module cycle_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);
  logic [WIDTH-1:0] remain;
  logic [WIDTH-1:0] next_remain;

  always_comb
  begin
    next_remain = remain;
    if (load)
      next_remain = count;
    else if (remain != '0)
      next_remain = remain - 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      remain <= '0;
    else
      remain <= next_remain;
  end

  assign done = (remain == '0);
endmodule // cycle_timer

//--- rtl/eeprom_host.sv
// Host controller driving a paged nonvolatile memory through its pins
`include "eeprom_host_params.svh"
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int                  POWERUP_CYC = `POWERUP_CYC,
  parameter int                  PROGRAM_CYC = `PROGRAM_CYC,
  parameter int                  WINDOW_CYC  = `LOAD_WINDOW_CYC,
  parameter logic [`ADDR_W-1:0]  CMD_A0      = `CMD_ADDR0,
  parameter logic [`ADDR_W-1:0]  CMD_A1      = `CMD_ADDR1,
  parameter logic [`ADDR_W-1:0]  CMD_A2      = `CMD_ADDR2,
  parameter logic [`DATA_W-1:0]  CMD_D0      = `CMD_DATA0,
  parameter logic [`DATA_W-1:0]  CMD_D1      = `CMD_DATA1,
  parameter logic [`DATA_W-1:0]  LOCK_D2     = `LOCK_ON_DATA,
  parameter logic [`DATA_W-1:0]  UNLOCK_D2   = `LOCK_OFF_DATA2
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire eeprom_host_pkg::request_t req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 lock_active,
  output logic [`DATA_W-1:0]        rd_data,
  output logic                      rd_valid,
  output logic                      busy,
  output eeprom_host_pkg::pins_t    pins,
  input  wire logic [`DATA_W-1:0]   data_in
);
  localparam int TW = 24;
  localparam int STROBE = `STROBE_CYC;
  localparam int SETUP  = `SETUP_CYC;

  typedef enum logic [3:0] {
    st_powerup = 4'b0000,
    st_idle    = 4'b0001,
    st_setup   = 4'b0010,
    st_strobe  = 4'b0011,
    st_hold    = 4'b0100,
    st_rd_on   = 4'b0101,
    st_rd_samp = 4'b0110,
    st_window  = 4'b0111,
    st_poll    = 4'b1000,
    st_poll_rd = 4'b1001
  } state_t;

  state_t              state, next_state;
  pins_t               next_pins;
  logic [1:0]          pre, next_pre;
  mem_word_t           cur, next_cur;
  mem_word_t           last_wr, next_last_wr;
  logic                is_last, next_is_last;
  logic [`DATA_W-1:0]  prev_rd, next_prev_rd;
  logic                poll_first, next_poll_first;
  logic [`DATA_W-1:0]  next_rd_data;
  logic                next_rd_valid;
  logic                t_load;
  logic [TW-1:0]       t_count;
  logic                t_done;
  logic [`DATA_W-1:0]  din_s1, din_s2;
  request_t            held, next_held;

  cycle_timer #(.WIDTH(TW)) timer (
    .clk   (clk),
    .rst   (rst),
    .load  (t_load),
    .count (t_count),
    .done  (t_done)
  );

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction

  function automatic mem_word_t prefix_word(input logic [1:0] i, input op_t op);
    prefix_word.addr = (i == 2'd0) ? CMD_A0 : (i == 2'd1) ? CMD_A1 : CMD_A2;
    prefix_word.data = (i == 2'd0) ? CMD_D0 : (i == 2'd1) ? CMD_D1 :
                       (op == op_unlock) ? UNLOCK_D2 : LOCK_D2;
  endfunction

  // Two-stage sampling of the data pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      din_s1 <= '0;
      din_s2 <= '0;
    end
    else
    begin
      din_s1 <= data_in;
      din_s2 <= din_s1;
    end
  end

  assign req_ready = (state == st_idle) ||
                     (state == st_window && !t_done && !is_last && req.op == op_write);
  assign busy      = (state != st_idle);

  always_comb
  begin
    next_state      = state;
    next_pins       = pins;
    next_pre        = pre;
    next_cur        = cur;
    next_last_wr    = last_wr;
    next_is_last    = is_last;
    next_prev_rd    = prev_rd;
    next_poll_first = poll_first;
    next_rd_data    = rd_data;
    next_rd_valid   = 1'b0;
    t_load          = 1'b0;
    t_count         = '0;
    case (state)
      st_powerup:
        if (t_done)
        begin
          t_load          = poll_first;
          t_count         = cyc(POWERUP_CYC);
          next_poll_first = 1'b0;
          next_state      = poll_first ? st_powerup : st_idle;
        end
      st_idle, st_window:
        if (req_valid && req_ready)
        begin
          next_is_last = req.last;
          next_cur     = req.word;
          if (req.op == op_read && state == st_idle)
          begin
            next_pins.addr            = req.word.addr;
            next_pins.chip_select_n   = 1'b0;
            next_pins.output_enable_n = 1'b0;
            next_pins.data_oe         = 1'b0;
            t_load     = 1'b1;
            t_count    = cyc(STROBE);
            next_state = st_rd_on;
          end
          else if (req.op != op_read)
          begin
            // Prefix with command writes for lock changes, or for a write from idle while locked
            if (req.op != op_write || (lock_active && state == st_idle))
            begin
              next_pre = 2'd3;
              next_cur = prefix_word(2'd0, req.op);
            end
            else
              next_pre = 2'd0;
            next_pins.addr            = next_cur.addr;
            next_pins.data_out        = next_cur.data;
            next_pins.data_oe         = 1'b1;
            next_pins.output_enable_n = 1'b1;
            next_pins.chip_select_n   = 1'b0;
            t_load     = 1'b1;
            t_count    = cyc(SETUP);
            next_state = st_setup;
          end
        end
        else if (state == st_window && t_done)
        begin
          next_is_last    = 1'b1;
          t_load          = !is_last;
          t_count         = cyc(WINDOW_CYC / 2);
          next_poll_first = 1'b1;
          next_state      = is_last ? st_poll : st_window;
        end
      st_setup:
        if (t_done)
        begin
          next_pins.write_strobe_n = 1'b0;
          t_load     = 1'b1;
          t_count    = cyc(STROBE);
          next_state = st_strobe;
        end
      st_strobe:
        if (t_done)
        begin
          next_pins.write_strobe_n = 1'b1;
          next_state               = st_hold;
        end
      st_hold:
      begin
        next_pins.chip_select_n = 1'b1;
        next_pins.data_oe       = 1'b0;
        t_load                  = 1'b1;
        t_count      = cyc(is_last ? WINDOW_CYC * 3 / 2 : WINDOW_CYC);
        next_last_wr = cur;
        next_state   = st_window;
        next_pre     = (pre == 2'd0) ? pre : pre - 2'd1;
        next_cur     = (pre == 2'd1) ? held.word : prefix_word(2'd3 - pre + 2'd1, held.op);
        if (pre > 2'd1 || (pre == 2'd1 && held.op == op_write))
        begin
          next_pins.chip_select_n = 1'b0;
          next_pins.data_oe       = 1'b1;
          next_pins.addr          = next_cur.addr;
          next_pins.data_out      = next_cur.data;
          t_count                 = cyc(SETUP);
          next_state              = st_setup;
        end
      end
      st_rd_on:
        if (t_done)
          next_state = st_rd_samp;
      st_rd_samp:
      begin
        next_rd_data              = din_s2;
        next_rd_valid             = 1'b1;
        next_pins.chip_select_n   = 1'b1;
        next_pins.output_enable_n = 1'b1;
        next_state                = st_idle;
      end
      st_poll:
      begin
        next_pins.addr            = last_wr.addr;
        next_pins.chip_select_n   = 1'b0;
        next_pins.output_enable_n = 1'b0;
        t_load     = 1'b1;
        t_count    = cyc(STROBE + 2);
        next_state = st_poll_rd;
      end
      st_poll_rd:
        if (t_done)
        begin
          next_pins.chip_select_n   = 1'b1;
          next_pins.output_enable_n = 1'b1;
          next_prev_rd              = din_s2;
          next_poll_first           = 1'b0;
          // Done when poll bit is true and toggle bit stopped
          if (din_s2[7] == last_wr.data[7] && !poll_first &&
              din_s2[6] == prev_rd[6])
            next_state = st_idle;
          else
            next_state = st_poll;
        end
      default:
        next_state = st_idle;
    endcase
  end

  always_comb
  begin
    next_held = held;
    if (req_valid && req_ready)
      next_held = req;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= st_powerup;
      pins       <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
                      addr: '0, data_out: '0, data_oe: 1'b0};
      pre        <= '0;
      cur        <= '0;
      last_wr    <= '0;
      is_last    <= 1'b0;
      prev_rd    <= '0;
      poll_first <= 1'b1;
      rd_data    <= '0;
      rd_valid   <= 1'b0;
      held       <= '0;
    end
    else
    begin
      state      <= next_state;
      pins       <= next_pins;
      pre        <= next_pre;
      cur        <= next_cur;
      last_wr    <= next_last_wr;
      is_last    <= next_is_last;
      prev_rd    <= next_prev_rd;
      poll_first <= next_poll_first;
      rd_data    <= next_rd_data;
      rd_valid   <= next_rd_valid;
      held       <= next_held;
    end
  end
endmodule // eeprom_host

//--- verif/eeprom_host_checker.sv
// Port assertions for the paged memory host controller
module eeprom_host_checker #(
  parameter int POWERUP_CYC = 20
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   req_ready,
  input wire logic                   rd_valid,
  input wire eeprom_host_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  int up;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      up <= 0;
    else if (up < POWERUP_CYC)
      up <= up + 1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_POWERUP: assert property (req_ready |-> up >= POWERUP_CYC - 1)
    else $error("request accepted before power-up delay");
  AST_READ_SEL: assert property (!pins.output_enable_n |-> !pins.chip_select_n && pins.write_strobe_n)
    else $error("read strobe without select or with write strobe");
  AST_BUS_FREE: assert property (pins.data_oe |-> pins.output_enable_n)
    else $error("host drives data while output enable low");
  AST_WE_SEL: assert property (!pins.write_strobe_n |-> !pins.chip_select_n && pins.output_enable_n)
    else $error("write strobe without select or with output enable");
  AST_WE_WIDTH: assert property ($fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*4])
    else $error("write strobe shorter than four cycles");
  AST_WE_HIGH: assert property ($rose(pins.write_strobe_n) |-> pins.write_strobe_n [*2])
    else $error("write strobe high time too short");
  AST_LATCH_STABLE: assert property (!pins.write_strobe_n |-> $stable(pins.addr) && $stable(pins.data_out))
    else $error("address or data moved during write strobe");
  AST_DATA_OE: assert property (!pins.write_strobe_n |-> pins.data_oe)
    else $error("data not driven during write strobe");
  cover property ($fell(pins.write_strobe_n));
  cover property ($fell(pins.output_enable_n));
  cover property (rd_valid);
endmodule // eeprom_host_checker

//--- verif/nv_memory_model.sv
// Behavioural model of the paged nonvolatile memory at its pins
`include "eeprom_host_params.svh"
module nv_memory_model #(
  parameter int PWR_CYC  = 20,
  parameter int WIN_CYC  = 70,
  parameter int PROG_CYC = 150
) (
  input  wire logic                   clk,
  input  wire eeprom_host_pkg::pins_t pins,
  output logic [`DATA_W-1:0]          data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  logic [7:0]   mem [2**`ADDR_W];
  logic [7:0]   pg_d [`PAGE_BYTES];
  logic [127:0] pg_v = '0;
  logic [9:0]   pg_a;
  logic [16:0]  wa;
  logic [7:0]   wd;
  logic [7:0]   last_d = 8'h00;
  logic [7:0]   bus_q = 8'h00;
  logic         ws_q = 0, rd_q = 0, loading = 0, prog = 0, tog = 0, locked = 0, unlock = 0;
  int           pwr = 0, win = 0, pcnt = 0, step = 0;
  wire ws = !pins.chip_select_n && !pins.write_strobe_n && pins.output_enable_n;
  wire rd = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n;
  initial
    foreach (mem[i]) mem[i] = 8'hff;
  // Released bus shows the inverse of its last level
  assign data_in = pins.data_oe ? pins.data_out : !rd ? ~bus_q :
    prog ? {~last_d[7], tog, last_d[5:0]} : mem[pins.addr];
  always @(posedge clk)
  begin
    if (pins.data_oe || rd)
      bus_q <= data_in;
    ws_q <= ws;
    rd_q <= rd;
    if (pwr < PWR_CYC)
      pwr <= pwr + 1;
    if (rd && !rd_q && prog)
      tog <= ~tog;
    if (ws && !ws_q)
      wa <= pins.addr;
    if (ws)
      wd <= pins.data_out;
    // Any low of one sampled cycle is wider than the noise limit
    if (!ws && ws_q && !prog && pwr >= PWR_CYC)
    begin
      loading <= 1'b1;
      win <= WIN_CYC;
      last_d <= wd;
      if (step == 0 && wa == `CMD_ADDR0 && wd == `CMD_DATA0)
        step <= 1;
      else if (step == 1 && wa == `CMD_ADDR1 && wd == `CMD_DATA1)
        step <= 2;
      else if (step == 2 && wa == `CMD_ADDR2 && (wd == `LOCK_ON_DATA || wd == `LOCK_OFF_DATA2))
      begin
        step <= 3;
        unlock <= (wd == `LOCK_OFF_DATA2);
      end
      else
      begin
        pg_d[wa[6:0]] <= wd;
        pg_v[wa[6:0]] <= 1'b1;
        pg_a <= wa[16:7];
      end
    end
    else if (loading && win > 1)
      win <= win - 1;
    else if (loading)
    begin
      loading <= 1'b0;
      prog <= 1'b1;
      pcnt <= PROG_CYC;
      for (int i = 0; i < 128; i++)
        if (pg_v[i] && (!locked || step == 3))
          mem[{pg_a, i[6:0]}] <= pg_d[i];
      pg_v <= '0;
      if (step == 3)
        locked <= !unlock;
      step <= 0;
    end
    if (prog && pcnt > 1)
      pcnt <= pcnt - 1;
    else if (prog)
      prog <= 1'b0;
  end
endmodule // nv_memory_model

//--- verif/test_paged_eeprom_write_control.sv
// Self-checking bench for the paged memory host controller
`include "eeprom_host_params.svh"
module test_paged_eeprom_write_control;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  logic       clk = 0, rst = 1, req_valid = 0, lock_active = 0;
  logic       req_ready, rd_valid, busy;
  request_t   req = '0;
  logic [7:0] rd_data, data_in;
  pins_t      pins;
  int         n_errors = 0, total_checks = 0;
  eeprom_host #(.POWERUP_CYC(20), .PROGRAM_CYC(200), .WINDOW_CYC(50)) uut (.clk(clk),
    .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .lock_active(lock_active), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .pins(pins), .data_in(data_in));
  nv_memory_model dev (.clk(clk), .pins(pins), .data_in(data_in));
  initial
    forever #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail_wait();
    n_errors++;
    $display("[ERR] %0t wait limit reached", $time);
    stop_test();
  endtask
  task automatic send(input op_t op, input logic [16:0] a, input logic [7:0] d, input logic l);
    int k;
    @(posedge clk);
    req <= '{op, l, '{a, d}};
    req_valid <= 1'b1;
    @(negedge clk);
    for (k = 0; req_ready !== 1'b1; k++)
    begin
      if (k == 5000)
        fail_wait();
      @(negedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    @(negedge clk);
    for (k = 0; busy !== 1'b0; k++)
    begin
      if (k == 3000)
        fail_wait();
      @(negedge clk);
    end
  endtask
  task automatic write_one(input logic [16:0] a, input logic [7:0] d);
    send(op_write, a, d, 1'b1);
    wait_idle();
  endtask
  task automatic read_chk(input logic [16:0] a, input logic [7:0] exp);
    int k;
    send(op_read, a, 8'h00, 1'b1);
    for (k = 0; rd_valid !== 1'b1; k++)
    begin
      if (k == 100)
        fail_wait();
      @(negedge clk);
    end
    check(rd_data, exp);
  endtask
  task automatic t_powerup();
    int k;
    for (k = 0; req_ready !== 1'b1; k++)
    begin
      if (k == 200)
        fail_wait();
      @(negedge clk);
    end
    check(k >= 19, 1);
    $display("test powerup done");
  endtask
  task automatic t_byte();
    write_one(17'h00123, 8'h5a);
    read_chk(17'h00123, 8'h5a);
    $display("test byte write done");
  endtask
  task automatic t_page();
    send(op_write, 17'h00205, 8'h3c, 1'b0);
    send(op_write, 17'h00201, 8'hc3, 1'b1);
    wait_idle();
    read_chk(17'h00205, 8'h3c);
    read_chk(17'h00201, 8'hc3);
    read_chk(17'h00203, 8'hff);
    $display("test page write done");
  endtask
  task automatic t_lock();
    send(op_lock, 17'h00000, 8'h00, 1'b1);
    wait_idle();
    check(dev.locked, 1);
    write_one(17'h00300, 8'h91);
    read_chk(17'h00300, 8'hff);
    @(posedge clk) lock_active <= 1'b1;
    write_one(17'h00300, 8'h22);
    read_chk(17'h00300, 8'h22);
    read_chk(`CMD_ADDR0, 8'hff);
    send(op_unlock, 17'h00000, 8'h00, 1'b1);
    wait_idle();
    check(dev.locked, 0);
    @(posedge clk) lock_active <= 1'b0;
    write_one(17'h00301, 8'h44);
    read_chk(17'h00301, 8'h44);
    $display("test protection done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_byte();
    t_page();
    t_lock();
    stop_test();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_wait();
  end
endmodule // test_paged_eeprom_write_control
bind eeprom_host eeprom_host_checker #(.POWERUP_CYC(POWERUP_CYC)) chk (.clk(clk), .rst(rst),
  .req_ready(req_ready), .rd_valid(rd_valid), .pins(pins));
